// ===== src/efiu_pkg.sv
// constants of the event flag interrupt unit
package efiu_pkg;
  localparam int          NUM_FLAGS     = 10;
  localparam logic [7:0]  OFS_IRQ_EN_0  = 8'h04;
  localparam logic [7:0]  OFS_IRQ_EN_1  = 8'h05;
  localparam logic [7:0]  OFS_FLAGS_0   = 8'h06;
  localparam logic [7:0]  OFS_FLAGS_1   = 8'h07;
  localparam logic [7:0]  RST_IRQ_EN_0  = 8'h00;
  localparam logic [7:0]  RST_IRQ_EN_1  = 8'h00;
  localparam logic [9:0]  RST_FLAGS     = 10'h000;
  localparam int          FLAGS_LO_W    = 8;
  localparam int          FLAGS_HI_W    = 2;
endpackage

// ===== src/efiu_top.sv
// event flag and interrupt request logic with byte-wide register port
`timescale 1ns/1ns
module efiu_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        soft_rst,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // event sources and their clears
  input  wire logic [9:0]  evt_src,
  output logic      [9:0]  src_clr,
  // interrupt pin
  output logic             irq_n_o,
  output logic             irq_n_oe
);

  // synchroniser and edge history
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  logic [9:0] prev_r;

  // flag and enable state
  logic [9:0] latch_r;
  logic [9:0] latch_nxt;
  logic [9:0] en_r;
  logic [9:0] en_nxt;

  // registered outputs
  logic [9:0] clr_r;
  logic [9:0] clr_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       irq_r;
  logic       irq_nxt;
  logic       pin_r;
  logic       pin_nxt;

  // one byte lane of a ten-bit vector; the upper lane holds two bits
  function automatic logic [7:0] lane_get(input logic [9:0] vec, input logic hi);
    lane_get = hi ? {6'h00, vec[9:8]} : vec[7:0];
  endfunction

  // bits named by a write to either lane, zero elsewhere
  function automatic logic [9:0] lane_mask(input logic [7:0] data, input logic lo_sel, input logic hi_sel);
    lane_mask = {hi_sel ? data[1:0] : 2'h0, lo_sel ? data : 8'h00};
  endfunction

  // written lanes replace the held value, other lanes keep it
  function automatic logic [9:0] lane_put(input logic [9:0] old, input logic [7:0] data,
                                          input logic lo_sel, input logic hi_sel);
    lane_put = {hi_sel ? data[1:0] : old[9:8], lo_sel ? data : old[7:0]};
  endfunction

  // address decode
  wire        sel_en0 = reg_addr == efiu_pkg::OFS_IRQ_EN_0;
  wire        sel_en1 = reg_addr == efiu_pkg::OFS_IRQ_EN_1;
  wire        sel_fl0 = reg_addr == efiu_pkg::OFS_FLAGS_0;
  wire        sel_fl1 = reg_addr == efiu_pkg::OFS_FLAGS_1;
  wire        sel_any = sel_en0 || sel_en1 || sel_fl0 || sel_fl1;
  wire        wr_en0  = reg_wr && sel_en0;
  wire        wr_en1  = reg_wr && sel_en1;
  wire        wr_fl0  = reg_wr && sel_fl0;
  wire        wr_fl1  = reg_wr && sel_fl1;

  // flag events and read-back view
  wire [9:0]  rise    = sync2_r & ~prev_r;
  wire [9:0]  set_v   = en_r & rise;
  wire [9:0]  w1c     = lane_mask(reg_wdata, wr_fl0, wr_fl1);
  wire [9:0]  armed   = en_r & latch_r;
  wire [9:0]  live    = ~en_r & sync2_r;
  wire [9:0]  view    = armed | live;
  wire [9:0]  rst_en  = {efiu_pkg::RST_IRQ_EN_1[1:0], efiu_pkg::RST_IRQ_EN_0};
  wire [7:0]  rd_en   = sel_en0 ? lane_get(en_r, 1'b0) : lane_get(en_r, 1'b1);
  wire [7:0]  rd_fl   = sel_fl0 ? lane_get(view, 1'b0) : lane_get(view, 1'b1);

  // next values
  assign en_nxt    = soft_rst ? rst_en : lane_put(en_r, reg_wdata, wr_en0, wr_en1);
  assign clr_nxt   = w1c;
  // set wins over a write-one clear that lands in the same cycle
  assign latch_nxt = soft_rst ? efiu_pkg::RST_FLAGS : ((latch_r & ~w1c) | set_v);
  assign irq_nxt   = |armed;
  assign pin_nxt   = 1'b0;
  assign rdata_nxt = !reg_rd              ? 8'h00 :
                     (sel_en0 || sel_en1) ? rd_en :
                     (sel_fl0 || sel_fl1) ? rd_fl : 8'h00;

  // two-flop synchroniser and edge history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 10'h000;
      sync2_r <= 10'h000;
      prev_r  <= 10'h000;
    end else begin
      sync1_r <= evt_src;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // latched flags
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= efiu_pkg::RST_FLAGS;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  // interrupt enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_r <= {efiu_pkg::RST_IRQ_EN_1[1:0], efiu_pkg::RST_IRQ_EN_0};
    end else begin
      en_r <= en_nxt;
    end
  end

  // source clear pulses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clr_r <= 10'h000;
    end else begin
      clr_r <= clr_nxt;
    end
  end

  // interrupt pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
      pin_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      pin_r <= pin_nxt;
    end
  end

  // read data
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs straight from their flip-flops
  assign reg_rdata = rdata_r;
  assign src_clr   = clr_r;
  assign irq_n_oe  = irq_r;
  assign irq_n_o   = pin_r;

  // per-flag checks
  for (genvar g = 0; g < efiu_pkg::NUM_FLAGS; g++) begin : g_flag
    a_flag_sets: assert property (@(posedge clock) disable iff (!arst_n)
      en_r[g] && rise[g] && !soft_rst
      |=> latch_r[g])
      else $error("enabled edge did not set flag");

    a_latch_holds: assert property (@(posedge clock) disable iff (!arst_n)
      latch_r[g] && !w1c[g] && !soft_rst
      |=> latch_r[g])
      else $error("latched flag dropped");

    a_w1c_clears: assert property (@(posedge clock) disable iff (!arst_n)
      w1c[g] && !set_v[g] && !soft_rst
      |=> !latch_r[g])
      else $error("write one did not clear flag");

    a_set_wins: assert property (@(posedge clock) disable iff (!arst_n)
      w1c[g] && set_v[g] && !soft_rst
      |=> latch_r[g])
      else $error("clear beat a same cycle set");

    a_no_set_off: assert property (@(posedge clock) disable iff (!arst_n)
      !en_r[g] && !latch_r[g] && !soft_rst
      |=> !latch_r[g])
      else $error("disabled flag latched");

    a_view_live: assert property (@(posedge clock) disable iff (!arst_n)
      !en_r[g]
      |-> view[g] == sync2_r[g])
      else $error("disabled flag not live");

    a_view_latch: assert property (@(posedge clock) disable iff (!arst_n)
      en_r[g]
      |-> view[g] == latch_r[g])
      else $error("enabled flag not latched view");

    a_src_pulse: assert property (@(posedge clock) disable iff (!arst_n)
      w1c[g]
      |=> src_clr[g])
      else $error("source clear missing");

    a_src_quiet: assert property (@(posedge clock) disable iff (!arst_n)
      !w1c[g]
      |=> !src_clr[g])
      else $error("source clear without write");

    a_sync_order: assert property (@(posedge clock) disable iff (!arst_n)
      $rose(sync2_r[g])
      |-> $past(sync1_r[g]))
      else $error("sync order broken");

    a_single_set: assert property (@(posedge clock) disable iff (!arst_n)
      rise[g]
      |=> !rise[g])
      else $error("edge seen twice");

    a_soft_clear: assert property (@(posedge clock) disable iff (!arst_n)
      soft_rst
      |=> !latch_r[g])
      else $error("soft reset kept flag");
  end

  // pin, interrupt, reset, enable write and read checks
  a_irq_follows: assert property (@(posedge clock) disable iff (!arst_n)
    |armed
    |=> irq_n_oe)
    else $error("irq not asserted");

  a_irq_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    !(|armed)
    |=> !irq_n_oe)
    else $error("irq without cause");

  a_pin_low: assert property (@(posedge clock) disable iff (!arst_n)
    irq_n_oe
    |-> !irq_n_o)
    else $error("pin driven high");

  a_soft_reset: assert property (@(posedge clock) disable iff (!arst_n)
    soft_rst
    |=> latch_r == efiu_pkg::RST_FLAGS)
    else $error("soft reset kept flags");

  a_soft_en: assert property (@(posedge clock) disable iff (!arst_n)
    soft_rst
    |=> en_r == rst_en)
    else $error("soft reset kept enables");

  a_en_write: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en0 && !soft_rst
    |=> en_r[7:0] == $past(reg_wdata))
    else $error("low enable write lost");

  a_en_write_hi: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en1 && !soft_rst
    |=> en_r[9:8] == $past(reg_wdata[1:0]))
    else $error("high enable write lost");

  a_en_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !wr_en0 && !wr_en1 && !soft_rst
    |=> $stable(en_r))
    else $error("enables changed without write");

  a_rd_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !reg_rd
    |=> reg_rdata == 8'h00)
    else $error("read data without read");

  a_rd_en: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && sel_en0
    |=> reg_rdata == $past(en_r[7:0]))
    else $error("enable read back wrong");

  a_rd_flags_hi: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && sel_fl1
    |=> reg_rdata[7:2] == 6'h00)
    else $error("unused flag bits not zero");

  a_rd_unmapped: assert property (@(posedge clock) disable iff (!arst_n)
    reg_rd && !sel_any
    |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // main scenarios
  c_irq_raise: cover property (@(posedge clock) disable iff (!arst_n) $rose(irq_n_oe));

  c_w1c_drop:  cover property (@(posedge clock) disable iff (!arst_n) $fell(irq_n_oe) && !$past(soft_rst));

  c_monitor:   cover property (@(posedge clock) disable iff (!arst_n) !en_r[0] && sync2_r[0]);

  c_set_clear: cover property (@(posedge clock) disable iff (!arst_n) w1c[0] && set_v[0]);
endmodule

// ===== testbench/efiu_host_line.sv
// host side of the interrupt line, with its pull-up
`timescale 1ns/1ns
module efiu_host_line (
  // open-drain pin in, resolved line out
  input  wire logic irq_n_o,
  input  wire logic irq_n_oe,
  output logic      irq_line
);
  // released line floats to the pull-up level
  assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
endmodule

// ===== testbench/tb_top.sv
// self-checking bench for the event flag interrupt unit
`timescale 1ns/1ns
module tb_top;
  logic       clock = 0, arst_n = 0, soft_rst = 0, reg_wr = 0, reg_rd = 0, irq_n_o, irq_n_oe, irq_line;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0] evt_src = 10'h000, src_clr, en;
  integer     failures = 0, total_checks = 0, seed = 32'hde4a, i;
  always #20 clock = ~clock;
  efiu_top efiu_top_i (.clock(clock), .arst_n(arst_n), .soft_rst(soft_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt_src(evt_src), .src_clr(src_clr),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
  efiu_host_line efiu_host_line_i (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_line(irq_line));
  // flag view of a rule-abiding device: latch when enabled, live source when not
  function automatic logic [9:0] exp_view(input logic [9:0] en_v, input logic [9:0] lat_v,
                                          input logic [9:0] src_v);
    exp_view = (en_v & lat_v) | (~en_v & src_v);
  endfunction
  function automatic logic [7:0] lane(input logic [9:0] v, input logic hi);
    lane = hi ? {6'h00, v[9:8]} : v[7:0];
  endfunction
  task automatic cmp_line(input logic exp_v);
    total_checks++;
    failures += (irq_line !== exp_v);
    if (irq_line !== exp_v) $display("MISMATCH %0t irq line %b exp %b", $time, irq_line, exp_v);
  endtask
  task automatic cmp_clr(input logic [9:0] exp_v);
    total_checks++;
    failures += (src_clr !== exp_v);
    if (src_clr !== exp_v) $display("MISMATCH %0t source clear %h exp %h", $time, src_clr, exp_v);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    failures += (got !== exp);
    if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, ~w, a, d};
    @(negedge clock) {reg_wr, reg_rd} = 2'b00;
    if (!w) cmp8(reg_rdata, d);
  endtask
  task automatic set_en(input logic [9:0] v);
    acc(1, 8'h04, v[7:0]);
    acc(1, 8'h05, {6'h00, v[9:8]});
  endtask
  task automatic chk_flags(input logic [9:0] v);
    acc(0, 8'h06, lane(v, 1'b0));
    acc(0, 8'h07, lane(v, 1'b1));
  endtask
  // hold sources long enough to pass the synchroniser and the latch
  task automatic pulse_src(input logic [9:0] v);
    @(negedge clock) evt_src = v;
    repeat (5) @(negedge clock);
  endtask
  task automatic drop_src;
    @(negedge clock) evt_src = 10'h000;
    repeat (3) @(negedge clock);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    arst_n = 1;
    cmp_line(1'b1);
    acc(0, 8'h04, 8'h00);
    acc(0, 8'h09, 8'h00);
    pulse_src(10'h3ff);
    cmp_line(1'b1);
    chk_flags(10'h3ff);
    drop_src();
    chk_flags(10'h000);
    $display("test monitor done");
    for (i = 0; i < 5; i++) begin
      en = (i == 4) ? 10'h3ff : 10'($random(seed));
      set_en(en);
      acc(0, 8'h04, lane(en, 1'b0));
      acc(0, 8'h05, lane(en, 1'b1));
      pulse_src(10'h3ff);
      drop_src();
      cmp_line(en == 10'h000);
      chk_flags(exp_view(en, 10'h3ff, 10'h000));
      set_en(10'h000);
      repeat (2) @(negedge clock);
      cmp_line(1'b1);
      chk_flags(10'h000);
      acc(1, 8'h06, 8'hff);
      cmp_clr(10'h0ff);
      acc(1, 8'h07, 8'h03);
      cmp_clr(10'h300);
      set_en(en);
      repeat (2) @(negedge clock);
      cmp_line(1'b1);
      chk_flags(10'h000);
      $display("test %0d done", i);
    end
    // source edge and write-one clear meet on one clock edge: the set wins
    set_en(10'h001);
    @(negedge clock) evt_src = 10'h001;
    @(negedge clock);
    acc(1, 8'h06, 8'h01);
    chk_flags(10'h001);
    cmp_line(1'b0);
    acc(1, 8'h06, 8'h01);
    repeat (2) @(negedge clock);
    cmp_line(1'b1);
    chk_flags(10'h000);
    $display("test set wins done");
    // asynchronous reset in mid run
    set_en(10'h3ff);
    pulse_src(10'h3fe);
    cmp_line(1'b0);
    @(negedge clock) arst_n = 0;
    @(negedge clock) evt_src = 10'h000;
    cmp_line(1'b1);
    @(negedge clock) arst_n = 1;
    acc(0, 8'h04, 8'h00);
    set_en(10'h3ff);
    chk_flags(10'h000);
    $display("test hard reset done");
    // software reset
    pulse_src(10'h3ff);
    cmp_line(1'b0);
    @(negedge clock) soft_rst = 1;
    @(negedge clock) {soft_rst, evt_src} = {1'b0, 10'h000};
    repeat (3) @(negedge clock);
    cmp_line(1'b1);
    acc(0, 8'h04, 8'h00);
    set_en(10'h3ff);
    chk_flags(10'h000);
    $display("test soft reset done");
    complete_run();
  end
endmodule
